/* inc/rcb_pkg.sv */
// Constants for the receive cell bus multi-PHY poll/select block.
// Assumes a 32-bit APB slave with word-aligned registers.
`default_nettype none
package rcb_pkg;
  // Register indexes as printed; byte address is four times the index
  localparam logic [11:0] RCB_IDX_PHY_ADDR = 12'h513;
  localparam logic [11:0] RCB_IDX_CH_PTR   = 12'h517;
  localparam logic [11:0] RCB_IDX_STATUS   = 12'h518;
  localparam int          RCB_AW           = 14;
  localparam logic [13:0] RCB_A_PHY_ADDR   = {RCB_IDX_PHY_ADDR, 2'b00};
  localparam logic [13:0] RCB_A_CH_PTR     = {RCB_IDX_CH_PTR, 2'b00};
  localparam logic [13:0] RCB_A_STATUS     = {RCB_IDX_STATUS, 2'b00};
  // Field layout
  localparam int          RCB_ADDR_W       = 5;
  localparam int          RCB_NCH          = 4;
  localparam int          RCB_CH_W         = 2;
  localparam int          RCB_DATA_W       = 16;
  // Status fields: [1:0] selected channel, [2] selected, [7:4] ready
  localparam int          RCB_ST_SEL_LSB   = 0;
  localparam int          RCB_ST_VLD_BIT   = 2;
  localparam int          RCB_ST_RDY_LSB   = 4;
  // Reset values
  localparam logic [4:0]  RCB_NULL_ADDR    = 5'h1f;
  localparam logic [4:0]  RCB_PTR_RESET    = 5'h00;
  // Cell shape: 54 bytes on a 16-bit bus
  localparam int          RCB_CELL_BYTES   = 54;
  localparam logic [4:0]  RCB_LAST_WORD    =
    5'(RCB_CELL_BYTES / (RCB_DATA_W / 8) - 1);
endpackage : rcb_pkg
`default_nettype wire

/* src/rcb_rx_multiphy.sv */
// Receive cell bus slave: answers address polls on the shared
// cell-available line and delivers cells from the selected channel.
// Assumes the link clock is slow against SYS_CLK (at least 8 cycles per
// link period) and the cell FIFO answers a pop on the next SYS_CLK edge.
//
// Behaviour
// - Read enable asserted while our address appears means poll only.
// - When addressed, cell-available is high iff a whole cell is queued.
// - Every link rising edge the address pins are compared with all four channel addresses.
// - With no match cell-available stays undriven and comparing continues.
// - Only the matching PHY drives cell-available; all others float.
// - Start-of-cell is high together with the first word of a cell.
// - A 54-byte cell goes out as 27 sixteen-bit words.
// - Address 0x1F matches no PHY, so the line floats when it is polled.
// - Own address seen while enable is negated makes the PHY selected.
// - Four channels each answer their own programmed address.
// - Polls of other addresses do not disturb the selected PHY's reads.
// - Polling is always on; no enabling step exists.
// - A channel pointer register picks which address the address register reaches.
`default_nettype none
module rcb_rx_multiphy
  import rcb_pkg::*;
(
  // System
  input  wire  logic                  SYS_CLK,
  input  wire  logic                  RST,
  input  wire  logic                  CE,
  // APB slave
  input  wire  logic                  PSEL,
  input  wire  logic                  PENABLE,
  input  wire  logic                  PWRITE,
  input  wire  logic [rcb_pkg::RCB_AW-1:0] PADDR,
  input  wire  logic [31:0]           PWDATA,
  output logic [31:0]                 PRDATA,
  output logic                        PREADY,
  output logic                        PSLVERR,
  // Link pins from the processor
  input  wire  logic                  RX_INTERFACE_CLOCK,
  input  wire  logic [4:0]            RX_PHY_ADDRESS_INPUTS,
  input  wire  logic                  RX_READ_ENABLE_N,
  // Link pins to the processor
  output logic                        RX_CELL_AVAILABLE_O,
  output logic                        RX_CELL_AVAILABLE_OE_N,
  output logic [15:0]                 RX_DATA_O,
  output logic                        RX_START_OF_CELL_O,
  output logic                        RX_DATA_OE_N,
  // Receive cell FIFO side
  input  wire  logic [3:0]            CELL_READY,
  output logic                        FIFO_POP,
  output logic [1:0]                  FIFO_CH,
  input  wire  logic [15:0]           FIFO_DATA
);
  import rcb_pkg::*;

  logic [2:0]  lclk_sync_reg;
  logic [4:0]  addr_s1_reg, addr_s2_reg, addr_s3_reg;
  logic [2:0]  enb_sync_reg;
  logic        lk_edge;
  logic [4:0]  ch_addr_reg [RCB_NCH];
  logic [4:0]  ch_ptr_reg;
  logic        hit;
  logic [1:0]  hit_ch;
  logic        sel_valid_reg;
  logic [1:0]  sel_ch_reg;
  logic [4:0]  word_idx_reg;
  logic        pop_reg;
  logic        pop_first_reg;
  logic        word_go;
  logic        apb_wr;
  logic [31:0] rd_next;
  logic        rd_err;

  // Two flops on every pin, a third stage so the sampled address is
  // the value from before the link edge; pins change after that edge
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      lclk_sync_reg <= 3'h0;
      addr_s1_reg   <= 5'h00;
      addr_s2_reg   <= 5'h00;
      addr_s3_reg   <= 5'h00;
      enb_sync_reg  <= 3'h7;
    end else if (CE) begin
      lclk_sync_reg <= {lclk_sync_reg[1:0], RX_INTERFACE_CLOCK};
      addr_s1_reg   <= RX_PHY_ADDRESS_INPUTS;
      addr_s2_reg   <= addr_s1_reg;
      addr_s3_reg   <= addr_s2_reg;
      enb_sync_reg  <= {enb_sync_reg[1:0], RX_READ_ENABLE_N};
    end
  end

  // Rising edge of the link clock seen after synchronisation
  assign lk_edge = CE & lclk_sync_reg[1] & ~lclk_sync_reg[2];

  // Address compare against all four channels; 0x1F never matches
  always_comb begin
    hit    = 1'b0;
    hit_ch = 2'h0;
    for (int i = 0; i < RCB_NCH; i++) begin
      if (addr_s3_reg == ch_addr_reg[i] &&
          addr_s3_reg != RCB_NULL_ADDR) begin
        hit    = 1'b1;
        hit_ch = 2'(i);
      end
    end
  end

  // Cell-available: driven with fill state on a match, else floating
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      RX_CELL_AVAILABLE_O    <= 1'b0;
      RX_CELL_AVAILABLE_OE_N <= 1'b1;
    end else if (lk_edge) begin
      RX_CELL_AVAILABLE_OE_N <= ~hit;
      RX_CELL_AVAILABLE_O    <= hit & CELL_READY[hit_ch];
    end
  end

  // Selection happens only while enable is negated, so polls made
  // with enable asserted leave the current selection alone
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      sel_valid_reg <= 1'b0;
      sel_ch_reg    <= 2'h0;
    end else if (lk_edge && enb_sync_reg[2] && hit) begin
      sel_valid_reg <= 1'b1;
      sel_ch_reg    <= hit_ch;
    end else if (lk_edge && enb_sync_reg[2] && !hit) begin
      sel_valid_reg <= 1'b0; // Another PHY was selected
    end
  end

  // A word moves on each enabled edge; a new cell needs a whole one queued
  assign word_go = lk_edge & sel_valid_reg & ~enb_sync_reg[2] &
                   ((word_idx_reg != 5'h00) |
                    CELL_READY[sel_ch_reg]);

  // Word counter within the cell; a fresh selection restarts the cell
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      word_idx_reg <= 5'h00;
    end else if (lk_edge && enb_sync_reg[2]) begin
      word_idx_reg <= 5'h00;
    end else if (word_go) begin
      word_idx_reg <= (word_idx_reg == RCB_LAST_WORD) ? 5'h00 :
                      word_idx_reg + 5'h01;
    end
  end

  // FIFO pop; data comes back one cycle later
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      pop_reg       <= 1'b0;
      pop_first_reg <= 1'b0;
    end else if (CE) begin
      pop_reg       <= word_go;
      pop_first_reg <= word_go && (word_idx_reg == 5'h00);
    end
  end
  assign FIFO_POP = word_go;
  assign FIFO_CH  = sel_ch_reg;

  // Data and start-of-cell registers
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      RX_DATA_O          <= 16'h0000;
      RX_START_OF_CELL_O <= 1'b0;
    end else if (CE && pop_reg) begin
      RX_DATA_O          <= FIFO_DATA;
      RX_START_OF_CELL_O <= pop_first_reg;
    end else if (lk_edge) begin
      RX_START_OF_CELL_O <= 1'b0; // Pulse lasts one link period
    end
  end

  // Data bus driven only while selected and enable asserted
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      RX_DATA_OE_N <= 1'b1;
    end else if (lk_edge) begin
      RX_DATA_OE_N <= ~(sel_valid_reg & ~enb_sync_reg[2]);
    end
  end

  // APB decode: zero wait states, error on unmapped addresses
  assign apb_wr  = CE & PSEL & PENABLE & PWRITE;
  assign PREADY  = 1'b1;

  // Channel pointer and per-channel addresses
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ch_ptr_reg <= RCB_PTR_RESET;
      for (int i = 0; i < RCB_NCH; i++) begin
        ch_addr_reg[i] <= RCB_NULL_ADDR;
      end
    end else if (apb_wr && PADDR == RCB_A_CH_PTR) begin
      ch_ptr_reg <= PWDATA[4:0];
    end else if (apb_wr && PADDR == RCB_A_PHY_ADDR &&
                 ch_ptr_reg < 5'(RCB_NCH)) begin
      ch_addr_reg[ch_ptr_reg[1:0]] <= PWDATA[4:0];
    end
  end

  // Read mux; unused bits read as zero
  always_comb begin
    rd_next = 32'h0000_0000;
    rd_err  = 1'b0;
    unique case (PADDR)
      RCB_A_CH_PTR:   rd_next[4:0] = ch_ptr_reg;
      RCB_A_PHY_ADDR: rd_next[4:0] = (ch_ptr_reg < 5'(RCB_NCH)) ?
                        ch_addr_reg[ch_ptr_reg[1:0]] : 5'h00;
      RCB_A_STATUS: begin
        rd_next[RCB_ST_SEL_LSB +: 2]  = sel_ch_reg;
        rd_next[RCB_ST_VLD_BIT]       = sel_valid_reg;
        rd_next[RCB_ST_RDY_LSB +: 4]  = CELL_READY;
      end
      default:        rd_err = 1'b1;
    endcase
  end
  // Read data is captured in the setup phase, so it comes from a flop yet
  // still stands through the zero-wait access phase; zero otherwise
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (CE) begin
      PRDATA <= (PSEL && !PENABLE && !PWRITE) ? rd_next : 32'h0000_0000;
    end
  end
  assign PSLVERR = PSEL & PENABLE & rd_err;

  // Checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  a_clav_nomatch_hiz: assert property (lk_edge && !hit |=>
    RX_CELL_AVAILABLE_OE_N) else $error("clav driven without match");
  a_clav_fill_level: assert property (lk_edge && hit |=>
    !RX_CELL_AVAILABLE_OE_N &&
    RX_CELL_AVAILABLE_O == $past(CELL_READY[hit_ch]))
    else $error("clav level wrong");
  a_null_addr_hiz: assert property (
    lk_edge && addr_s3_reg == RCB_NULL_ADDR |=> RX_CELL_AVAILABLE_OE_N)
    else $error("0x1F poll drove clav");
  a_clav_owner_only: assert property (
    $fell(RX_CELL_AVAILABLE_OE_N) |-> $past(hit))
    else $error("clav driven by non-addressed PHY");
  a_select_on_negate: assert property (
    lk_edge && enb_sync_reg[2] && hit |=>
    sel_valid_reg && sel_ch_reg == $past(hit_ch))
    else $error("selection missed");
  a_poll_keeps_sel: assert property (
    lk_edge && !enb_sync_reg[2] |=> $stable(sel_ch_reg) &&
    $stable(sel_valid_reg)) else $error("poll changed selection");
  a_soc_first_word: assert property (
    pop_reg && pop_first_reg |=> RX_START_OF_CELL_O ##0
    $past(word_idx_reg, 2) == 5'h00)
    else $error("start of cell not on first word");
  a_cell_27_words: assert property (
    word_go && word_idx_reg == RCB_LAST_WORD |=> word_idx_reg == 5'h00)
    else $error("cell length wrong");
  a_data_only_sel: assert property (
    $fell(RX_DATA_OE_N) |-> $past(sel_valid_reg) &&
    !$past(enb_sync_reg[2], 1)) else $error("data driven unselected");
  a_addr_prog: assert property (
    apb_wr && PADDR == RCB_A_PHY_ADDR && ch_ptr_reg < 5'(RCB_NCH) |=>
    ch_addr_reg[$past(ch_ptr_reg[1:0])] == $past(PWDATA[4:0]))
    else $error("address write lost");

  c_poll_hit: cover property (lk_edge && hit && !enb_sync_reg[2]);
  c_select: cover property (lk_edge && hit && enb_sync_reg[2]);
  c_cell_end: cover property (word_go && word_idx_reg == RCB_LAST_WORD);
  c_null_poll: cover property (lk_edge && addr_s3_reg == RCB_NULL_ADDR);

  // Cell-available moves only on a detected link edge; the processor may
  // sample them at any time within the period
  a_clav_hold_between: assert property (
    !lk_edge |=> $stable(RX_CELL_AVAILABLE_OE_N) &&
    $stable(RX_CELL_AVAILABLE_O)) else $error("clav moved off edge");

  // Data enable moves only on a link edge too
  a_dataoe_hold: assert property (
    !lk_edge |=> $stable(RX_DATA_OE_N))
    else $error("data enable moved off edge");

  // A fresh cell is never started without a whole cell queued
  a_cell_needs_ready: assert property (
    word_go && word_idx_reg == 5'h00 |-> CELL_READY[sel_ch_reg])
    else $error("cell started without a whole cell");

  // At most one word leaves the FIFO per link edge, only when selected
  a_pop_one_edge: assert property (
    FIFO_POP |-> lk_edge && sel_valid_reg)
    else $error("pop without link edge");

  // Start-of-cell lasts one link period unless a new first word follows
  a_soc_one_link: assert property (
    lk_edge && !pop_reg |=> !RX_START_OF_CELL_O)
    else $error("start of cell too long");
endmodule : rcb_rx_multiphy
`default_nettype wire

/* bench/rcb_proc_model.sv */
// Processor model: makes the link clock, one pulse per bench request, and presents the
// address and enable pins four system cycles before each link rise.
// Assumes the bench asks for new pin values at most once a link period.
`default_nettype none
module rcb_proc_model (
  // System
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Requested pin values
  input  wire logic [4:0] want_addr,
  input  wire logic       want_en_n,
  input  wire logic       want_tgl,
  // Link pins
  output logic            link_clk,
  output logic [4:0]      addr,
  output logic            en_n,
  output logic [2:0]      phase
);
  timeunit 1ns;
  timeprecision 1ns;
  logic seen_reg, run_reg;
  // Eight system cycles per link period; pins move on the fall so they
  // are settled well ahead of the rise; the link clock only pulses when
  // the bench toggled want_tgl, so held pins never give a second edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      phase    <= 3'h0;
      link_clk <= 1'b0;
      addr     <= 5'h1f;
      en_n     <= 1'b1;
      seen_reg <= 1'b0;
      run_reg  <= 1'b0;
    end else begin
      phase    <= phase + 3'h1;
      link_clk <= (phase == 3'h3 && run_reg) ? 1'b1 :
                  (phase == 3'h7) ? 1'b0 : link_clk;
      if (phase == 3'h7) begin
        run_reg  <= want_tgl != seen_reg;
        seen_reg <= want_tgl;
        if (want_tgl != seen_reg) begin
          addr <= want_addr;
          en_n <= want_en_n;
        end
      end
    end
  end
endmodule // rcb_proc_model
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench for the receive cell bus slave.
// Assumes rcb_pkg and the processor model are compiled first.
`default_nettype none
module testbench;
  import rcb_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        link_clk, en_n, want_en_n, want_tgl, clav_o, clav_oe_n;
  logic        soc, data_oe_n, pop;
  logic [4:0]  addr, want_addr;
  logic [4:0]  pa [4];
  logic [2:0]  phase;
  logic [15:0] rdata, fdata;
  logic [1:0]  fch;
  logic [3:0]  ready;
  logic [7:0]  pops;
  int          err_total, checked, cyc;

  // Device; clock enable held on
  rcb_rx_multiphy rcb_rx_multiphy_inst (
    .SYS_CLK(sys_clk), .RST(rst), .CE(1'b1), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RX_INTERFACE_CLOCK(link_clk), .RX_PHY_ADDRESS_INPUTS(addr),
    .RX_READ_ENABLE_N(en_n), .RX_CELL_AVAILABLE_O(clav_o),
    .RX_CELL_AVAILABLE_OE_N(clav_oe_n), .RX_DATA_O(rdata),
    .RX_START_OF_CELL_O(soc), .RX_DATA_OE_N(data_oe_n),
    .CELL_READY(ready), .FIFO_POP(pop), .FIFO_CH(fch), .FIFO_DATA(fdata));

  rcb_proc_model rcb_proc_model_inst (
    .sys_clk(sys_clk), .rst(rst), .want_addr(want_addr),
    .want_en_n(want_en_n), .want_tgl(want_tgl), .link_clk(link_clk),
    .addr(addr), .en_n(en_n), .phase(phase));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Cell FIFO: word tagged with channel and pop count; junk when idle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pops  <= 8'h00;
      fdata <= 16'h0000;
    end else if (pop) begin
      fdata <= {fch, 6'h00, pops};
      pops  <= pops + 8'h01;
    end else begin
      fdata <= ~fdata;
    end
  end

  // Hang guard: runs need well under 3000 cycles
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string what);
    checked = checked + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  task automatic wait_ph(input logic [2:0] p);
    do @(posedge sys_clk); while (phase !== p);
  endtask

  // One link edge: pins picked up, rise seen, outputs settled
  task automatic lnk(input logic [4:0] a, input logic e);
    want_addr <= a;
    want_en_n <= e;
    want_tgl  <= ~want_tgl;
    wait_ph(3'h7);
    wait_ph(3'h3);
    wait_ph(3'h2);
  endtask

  task automatic apb(input logic wr, input logic [13:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    apb(1'b0, RCB_A_CH_PTR, 32'h0, q, e);
    chk(q, 32'h0, "pointer reset");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, RCB_A_CH_PTR, 32'(i), q, e);
      apb(1'b1, RCB_A_PHY_ADDR, 32'(pa[i]), q, e);
    end
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, RCB_A_CH_PTR, 32'(i), q, e);
      apb(1'b0, RCB_A_PHY_ADDR, 32'h0, q, e);
      chk(q, 32'(pa[i]), "address readback");
    end
    apb(1'b0, 14'h1000, 32'h0, q, e);
    chk({31'h0, e}, 32'h1, "unmapped");
  endtask

  task automatic t_poll();
    ready <= 4'b0101;
    for (int i = 0; i < 4; i++) begin
      lnk(pa[i], 1'b0);
      chk(32'({clav_oe_n, clav_o}), 32'({1'b0, ready[i]}), "poll");
      chk(32'(data_oe_n), 32'h1, "poll only");
    end
    lnk(RCB_NULL_ADDR, 1'b0);
    chk(32'(clav_oe_n), 32'h1, "null poll");
    lnk(5'h11, 1'b0);
    chk(32'(clav_oe_n), 32'h1, "no match");
  endtask

  // Select, then read a whole cell plus the next cell's first word
  task automatic t_read(input logic [1:0] ch);
    logic [7:0]  base;
    logic [31:0] q;
    logic        e;
    base = pops;
    ready <= 4'b1111;
    lnk(pa[ch], 1'b1);
    chk(32'(data_oe_n), 32'h1, "held off");
    // Status: ready in [7:4], selected flag in [2], channel in [1:0]
    apb(1'b0, RCB_A_STATUS, 32'h0, q, e);
    chk(q, 32'({4'hf, 1'b0, 1'b1, ch}), "status");
    for (int w = 0; w < 28; w++) begin
      lnk((w == 9) ? pa[ch ^ 2'd1] : pa[ch], 1'b0);
      chk(32'(data_oe_n), 32'h0, "driving");
      chk(32'(soc), 32'(w % 27 == 0), "start of cell");
      chk(32'(rdata), 32'({ch, 6'h00, 8'(base + w)}), "word");
    end
    lnk(5'h11, 1'b1);
    lnk(5'h11, 1'b0);
    chk(32'(data_oe_n), 32'h1, "released");
  endtask

  initial begin
    pa = '{5'h00, 5'h05, 5'h0a, 5'h1e};
    {err_total, checked, cyc} = '0;
    {rst, psel, penable, pwrite} = 4'b1000;
    {paddr, pwdata, ready} = '0;
    want_addr = 5'h1f;
    want_en_n = 1'b1;
    want_tgl = 1'b0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_poll();
    t_read(2'd1);
    t_read(2'd3);
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
